// >>> dv/address_mode_reset_control_bench.sv
// Self-checking bench for the address mode and reset controller
`timescale 1ns/1ps
module address_mode_reset_control_bench;
    logic ref_clk;
    logic arst_n;
    logic hw_rst_n;
    logic [7:0] nv_init;
    amr_pkg::amr_apb_req_t req;
    amr_pkg::amr_apb_rsp_t rsp;
    amr_pkg::amr_spi_t spi;
    logic addr4_mode;
    logic [7:0] sr1_out;
    logic nv_wr;
    logic [7:0] nv_data;
    logic [31:0] rdat;
    logic err;
    logic [31:0] a;
    logic [7:0] x;
    logic [1:0] wid;
    integer seed;
    int k;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    int nvw = 0;

    amr_ctrl DUT (.ref_clk(ref_clk), .arst_n(arst_n), .apb_req(req),
        .apb_rsp(rsp), .spi(spi), .hw_rst_n(hw_rst_n),
        .nv_sr1_init(nv_init), .addr4_mode(addr4_mode),
        .sr1_out(sr1_out), .nv_wr(nv_wr), .nv_data(nv_data));
    amr_host_model host (.ref_clk(ref_clk), .spi(spi));

    // ======================================================
    // Clock, store pulse count and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (nv_wr === 1'b1) begin
            nvw <= nvw + 1;
        end
        if (cyc == 30000) begin
            miscompares++;
            end_sim();
        end
    end

    // ======================================================
    // Helpers
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Request held until ready is seen at an edge
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= ad;
        req.pwdata <= d;
        @(posedge ref_clk);
        req.penable <= 1'b1;
        @(posedge ref_clk);
        // Only pready or the bench timeout ends this wait
        while (rsp.pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rdat = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(rdat, e);
    endtask
    task op(input logic [7:0] o);
        host.frame({32'h0, o}, 8, wid);
    endtask
    function automatic logic [31:0] adr_exp(logic [31:0] v, logic four);
        return four ? v : {8'h00, v[23:0]};
    endfunction
    // Address opcode picked by k: mode-dependent or always 4-byte
    function automatic logic [7:0] adr_op(int k, logic four);
        case (k)
            0: return four ? 8'h13 : 8'h03;
            1: return four ? 8'h12 : 8'h02;
            default: return four ? 8'h21 : 8'h20;
        endcase
    endfunction
    task end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ======================================================
    // Main sequence
    initial begin
        seed = 32'hfced;
        req = '0;
        arst_n = 1'b0;
        hw_rst_n = 1'b1;
        nv_init = 8'($random(seed));
        wid = 2'h0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({24'h0, sr1_out}, {24'h0, nv_init});
        rd(8'h14, {8'h25, 10'h0e5, 6'h30, 1'b1, 7'h68});
        apb(1'b0, 8'hfc, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rdat, 32'h0);
        for (int w = 0; w < 3; w++) begin
            wid = 2'(w);
            apb(1'b1, 8'h00, {30'h0, wid});
            a = $random(seed);
            k = {$random(seed)} % 3;
            op(8'hb7);
            chk({31'h0, addr4_mode}, 32'h1);
            host.frame({adr_op(k, 1'b0), a}, 40, wid);
            rd(8'h10, adr_exp(a, 1'b1));
            op(8'he9);
            chk({31'h0, addr4_mode}, 32'h0);
            host.frame({8'h00, adr_op(k, 1'b0), a[23:0]}, 32, wid);
            rd(8'h10, adr_exp(a, 1'b0));
            host.frame({adr_op(k, 1'b1), a}, 40, wid);
            rd(8'h10, adr_exp(a, 1'b1));
            rd(8'h18, {24'h0, adr_op(k, 1'b1)});
            // The reset pair works on every wire width
            op(8'hb7);
            op(8'h66);
            op(8'h99);
            chk({31'h0, addr4_mode}, 32'h0);
        end
        // An instruction between the pair disarms the reset
        apb(1'b1, 8'h08, 32'h3);
        op(8'hb7);
        op(8'h66);
        rd(8'h04, 32'h3);
        op(8'h06);
        op(8'h99);
        chk({31'h0, addr4_mode}, 32'h1);
        op(8'h66);
        op(8'h99);
        chk({31'h0, addr4_mode}, 32'h0);
        op(8'hb7);
        hw_rst_n <= 1'b0;
        @(posedge ref_clk);
        hw_rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({31'h0, addr4_mode}, 32'h0);
        rd(8'h08, 32'h3);
        // Store, then override, then a write with no enable left
        x = 8'($random(seed));
        op(8'h06);
        host.frame({24'h0, 8'h01, x}, 16, wid);
        chk({16'(nvw), nv_data, sr1_out}, {16'h1, x, x});
        op(8'h50);
        host.frame({24'h0, 8'h01, ~x}, 16, wid);
        chk({16'(nvw), nv_data, sr1_out}, {16'h1, x, ~x});
        host.frame({24'h0, 8'h01, x}, 16, wid);
        op(8'h66);
        op(8'h99);
        chk({16'(nvw), nv_data, sr1_out}, {16'h1, x, ~x});
        // Opcodes are ignored until continuous mode is left
        apb(1'b1, 8'h00, 32'h6);
        op(8'hb7);
        chk({31'h0, addr4_mode}, 32'h0);
        host.cont_exit();
        op(8'hb7);
        chk({31'h0, addr4_mode}, 32'h1);
        end_sim();
    end
endmodule

// >>> dv/amr_ctrl_assertions.sv
// Port-level checks for the address mode and reset controller
`timescale 1ns/1ps
module amr_ctrl_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire amr_pkg::amr_apb_req_t apb_req,
    input wire amr_pkg::amr_apb_rsp_t apb_rsp,
    input wire amr_pkg::amr_spi_t spi,
    input wire logic hw_rst_n,
    input wire logic [7:0] nv_sr1_init,
    input wire logic addr4_mode,
    input wire logic [7:0] sr1_out,
    input wire logic nv_wr,
    input wire logic [7:0] nv_data
);
    // ======================================================
    // One clock domain, reset disables everything
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // Read of the parameter word while its answer stands
    sequence s_pw;
        apb_rsp.pready && apb_req.psel && !apb_req.pwrite
            && apb_req.paddr == 8'h14;
    endsequence

    // ======================================================
    // Bus answers
    a_param_word: assert property (s_pw |->
        apb_rsp.prdata == 32'h253970e8)
        else $error("parameter word wrong");
    a_entry_bits: assert property (s_pw |->
        apb_rsp.prdata[31:24] == 8'h25)
        else $error("entry field wrong");
    a_apb_one_wait: assert property (
        apb_req.psel && !apb_req.penable
        |=> !apb_rsp.pready ##1 apb_rsp.pready)
        else $error("answer not after one wait state");
    a_ready_pulse: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held too long");

    // ======================================================
    // Address mode and status register 1
    // Mode may only move once a frame has closed or a reset came
    a_4b_rise: assert property ($rose(addr4_mode) |->
        $past(spi.cs_n))
        else $error("mode entered inside a frame");
    a_4b_fall: assert property ($fell(addr4_mode) |->
        $past(spi.cs_n) || !$past(hw_rst_n) || !$past(hw_rst_n, 2))
        else $error("mode left without cause");
    a_hwrst_clears: assert property (!hw_rst_n |->
        ##[1:2] !addr4_mode)
        else $error("hardware reset kept 4-byte mode");
    a_nvwr_pulse: assert property (nv_wr |=> !nv_wr)
        else $error("store pulse too long");
    a_nvwr_frame: assert property (nv_wr |-> $past(spi.cs_n))
        else $error("store inside a frame");
    a_sr1_quiet: assert property ($changed(sr1_out) |->
        $past(spi.cs_n))
        else $error("status changed inside a frame");

    cover property (s_pw);
    cover property ($rose(addr4_mode));
    cover property (nv_wr);
endmodule

bind amr_ctrl amr_ctrl_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .spi(spi), .hw_rst_n(hw_rst_n),
    .nv_sr1_init(nv_sr1_init), .addr4_mode(addr4_mode),
    .sr1_out(sr1_out), .nv_wr(nv_wr), .nv_data(nv_data));

// >>> dv/amr_host_model.sv
// Behavioural host controller driving the serial pins
`timescale 1ns/1ps
module amr_host_model (
    input wire logic ref_clk,
    output amr_pkg::amr_spi_t spi
);
    // ======================================================
    // Idle bus: clock parked low, chip select pulled high
    initial begin
        spi = '{sck: 1'b0, cs_n: 1'b1, io: 4'ha};
    end

    // One frame, MSB first, width bits per clock; slow phases
    // keep every edge visible to the sampling clock
    task frame(input logic [39:0] d, input int nb, input logic [1:0] w);
        int bw;
        logic [3:0] m;
        bw = (w == 2'h0) ? 1 : ((w == 2'h1) ? 2 : 4);
        m = 4'((1 << bw) - 1);
        spi.cs_n <= 1'b0;
        for (int i = nb; i > 0; i -= bw) begin
            spi.io <= 4'(d >> (i - bw)) & m;
            repeat (2) @(posedge ref_clk);
            spi.sck <= 1'b1;
            repeat (2) @(posedge ref_clk);
            spi.sck <= 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        spi.cs_n <= 1'b1;
        spi.io <= ~spi.io; // Released lines do not keep data
        repeat (4) @(posedge ref_clk);
    endtask

    // All ones on four lines for eight clocks ends continuous mode
    task cont_exit();
        frame(40'hffffffff, 32, 2'h2);
    endtask
endmodule

// >>> verilog/amr_ctrl.sv
// Serial command decoder for address mode, soft reset and SR1 enables
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "amr_regs.svh"

module amr_ctrl (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire amr_pkg::amr_apb_req_t apb_req,
    output amr_pkg::amr_apb_rsp_t apb_rsp,
    input wire amr_pkg::amr_spi_t spi,
    input wire logic hw_rst_n,
    input wire logic [7:0] nv_sr1_init,
    output logic addr4_mode,
    output logic [7:0] sr1_out,
    output logic nv_wr,
    output logic [7:0] nv_data
);

    // ======================================================
    // Helpers
    // Shift the wires in use into the low end, MSB first
    function automatic logic [31:0] shift_in(input logic [31:0] v,
                                             input logic [1:0] w,
                                             input logic [3:0] io);
        case (w)
            2'h0: return {v[30:0], io[0]};
            2'h1: return {v[29:0], io[1:0]};
            default: return {v[27:0], io};
        endcase
    endfunction

    // Bits taken on each serial clock for a given wire width;
    // the spare width code 3 falls back to four wires
    function automatic logic [6:0] bits_per(input logic [1:0] w);
        case (w)
            2'h0: return 7'h01;
            2'h1: return 7'h02;
            default: return 7'h04;
        endcase
    endfunction

    // Opcodes followed by an address; only these leave the command
    // phase for an address phase
    function automatic logic is_adr(input logic [7:0] op);
        return op == `AMR_OP_READ || op == `AMR_OP_PP ||
               op == `AMR_OP_SE || is_adr4(op);
    endfunction

    // Opcodes whose address is 32 bits in either address mode
    function automatic logic is_adr4(input logic [7:0] op);
        return op == `AMR_OP_READ4 || op == `AMR_OP_PP4 ||
               op == `AMR_OP_SE4;
    endfunction

    // Parameter word is fixed; built from its fields
    // Field order from the top: entry, exit, soft reset, one, SR1 scheme
    localparam logic [31:0] SFDP_WORD = {`AMR_SFDP_ENTRY,
        `AMR_SFDP_EXIT, `AMR_SFDP_SRST, `AMR_SFDP_RFU,
        `AMR_SFDP_SR1WE};

    // Whole controller state in one struct: one next-state process
    // fills st_d and one register stage holds st_q
    amr_pkg::amr_st_t st_q;
    amr_pkg::amr_st_t st_d;

    // ======================================================
    // Next state
    always_comb begin
        // Scratch values; each is cleared first so no latch appears
        logic rise;
        logic acc;
        logic hit;
        logic [31:0] rd;
        logic [6:0] nb;
        logic nb8;
        rise = 1'b0;
        acc = 1'b0;
        hit = 1'b0;
        rd = 32'h0;
        nb = 7'h0;
        nb8 = 1'b0;
        // Everything holds by default; the store strobe and bus answer are pulses and
        // the pin history is refreshed on every cycle
        st_d = st_q;
        st_d.nv_wr = 1'b0;
        st_d.sck_q = spi.sck;
        st_d.cs_q = spi.cs_n;
        // The serial clock is only sampled, so it must stay high and low
        // for at least one clock each or a rise is missed
        rise = spi.sck & ~st_q.sck_q;

        // Catch the stored SR1 once after power-up
        // The flag keeps later changes on the init input from leaking in
        if (!st_q.loaded) begin
            st_d.loaded = 1'b1;
            st_d.nvsr = nv_sr1_init;
        end

        // Bus reads are prepared in the cycle before pready
        // Unmapped offsets answer with an error and read as zero
        hit = 1'b1;
        case (apb_req.paddr)
            `AMR_CTRL_OFS: rd = {30'h0, st_q.width};
            `AMR_STAT_OFS: rd = {26'h0, st_q.cont, st_q.vol_act,
                                 st_q.vol_en, st_q.wel, st_q.armed,
                                 st_q.addr4};
            `AMR_EVT_OFS: rd = {30'h0, st_q.evt};
            `AMR_SR1_OFS: rd = {16'h0, st_q.nvsr, st_q.sr1};
            `AMR_ADDR_OFS: rd = st_q.addr;
            `AMR_SFDP_OFS: rd = SFDP_WORD;
            `AMR_OPC_OFS: rd = {24'h0, st_q.last_opc};
            default: hit = 1'b0;
        endcase

        // Access phase answered one cycle after it is first seen; the
        // answer comes from flops, which costs the one wait state
        acc = apb_req.psel & apb_req.penable;
        st_d.rsp.pready = 1'b0;
        st_d.rsp.pslverr = 1'b0;
        st_d.rsp.prdata = 32'h0;
        if (acc && !st_q.rsp.pready) begin
            st_d.rsp.pready = 1'b1;
            st_d.rsp.pslverr = ~hit;
            st_d.rsp.prdata = apb_req.pwrite ? 32'h0 : rd;
        end
        // Writes land on the edge that sees pready high
        // The continuous mode bit only sets; the exit pattern clears it
        if (acc && st_q.rsp.pready && apb_req.pwrite) begin
            case (apb_req.paddr)
                `AMR_CTRL_OFS: begin
                    st_d.width = apb_req.pwdata[1:0];
                    if (apb_req.pwdata[`AMR_CTRL_CONT]) begin
                        st_d.cont = 1'b1;
                    end
                end
                `AMR_EVT_OFS: st_d.evt = st_q.evt & ~apb_req.pwdata[1:0];
                default: ;
            endcase
        end

        // Serial frame: start, clock edges, end
        // A frame cut short by chip select is dropped, never half applied
        if (st_q.cs_q && !spi.cs_n) begin
            st_d.nbits = 7'h0;
            st_d.ffcnt = 4'h0;
            // Opcodes are not decoded while continuous mode holds
            st_d.fsm = st_q.cont ? amr_pkg::amr_mode
                                 : amr_pkg::amr_cmd;
        end else if (!spi.cs_n && rise) begin
            // One serial clock: shift, count, move between phases
            case (st_q.fsm)
                amr_pkg::amr_mode: begin
                    // Count back-to-back all-ones clocks; any other
                    // value on the lines starts the count again
                    if (spi.io == `AMR_ALL_ONES) begin
                        st_d.ffcnt = st_q.ffcnt + 4'h1;
                    end else begin
                        st_d.ffcnt = 4'h0;
                    end
                    // Rest of this frame is ignored; the next one decodes
                    if (st_d.ffcnt == `AMR_CONT_EXIT_CLKS) begin
                        st_d.cont = 1'b0;
                        st_d.fsm = amr_pkg::amr_idle;
                    end
                end
                amr_pkg::amr_cmd, amr_pkg::amr_adr,
                amr_pkg::amr_dat: begin
                    st_d.sh = shift_in(st_q.sh, st_q.width,
                                       spi.io);
                    // Counter stops once past 63 so long data cannot wrap
                    nb = st_q.nbits + bits_per(st_q.width);
                    st_d.nbits = (st_q.nbits > 7'h3f) ? st_q.nbits : nb;
                    // Opcode byte complete: choose address or data phase
                    if (st_q.fsm == amr_pkg::amr_cmd &&
                        st_d.nbits == 7'h08) begin
                        st_d.opc = st_d.sh[7:0];
                        if (is_adr(st_d.sh[7:0])) begin
                            st_d.fsm = amr_pkg::amr_adr;
                            // Address length set by mode or opcode
                            st_d.need = (st_q.addr4 ||
                                is_adr4(st_d.sh[7:0])) ? 7'h28
                                : 7'h20;
                        end else begin
                            st_d.fsm = amr_pkg::amr_dat;
                        end
                    end
                    // Address complete: kept for software to read back
                    if (st_q.fsm == amr_pkg::amr_adr &&
                        st_d.nbits == st_q.need) begin
                        st_d.addr = (st_q.need == 7'h28) ? st_d.sh
                            : {8'h0, st_d.sh[23:0]};
                        st_d.fsm = amr_pkg::amr_dat;
                    end
                end
                default: ;
            endcase
        end else if (!st_q.cs_q && spi.cs_n) begin
            // Frame end: back to idle whatever phase was reached
            st_d.fsm = amr_pkg::amr_idle;
            // Commands act at chip select release, whole bytes only
            if (st_q.fsm != amr_pkg::amr_mode &&
                st_q.fsm != amr_pkg::amr_idle &&
                st_q.nbits >= 7'h08) begin
                nb8 = st_q.nbits == 7'h08;
                st_d.last_opc = st_q.opc;
                // Any other whole opcode disarms the reset pair
                st_d.armed = nb8 &&
                    st_q.opc == `AMR_OP_RSTEN;
                // Mode and enable opcodes count only as a lone byte
                if (nb8) begin
                    case (st_q.opc)
                        `AMR_OP_EN4B: st_d.addr4 = 1'b1;
                        `AMR_OP_EX4B: st_d.addr4 = 1'b0;
                        `AMR_OP_WREN: st_d.wel = 1'b1;
                        `AMR_OP_VWREN: st_d.vol_en = 1'b1;
                        // Needs the enable as the frame just before
                        `AMR_OP_RST: begin
                            if (st_q.armed) begin
                                // Volatile SR1 survives, power only
                                st_d.addr4 = 1'b0;
                                st_d.wel = 1'b0;
                                st_d.vol_en = 1'b0;
                                st_d.evt[`AMR_EVT_SRST] = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
                // Status write goes to whichever copy is enabled
                // The volatile enable wins; either way both enables clear
                if (st_q.opc == `AMR_OP_WRSR &&
                    st_q.nbits == 7'h10) begin
                    if (st_q.vol_en) begin
                        st_d.vsr = st_q.sh[7:0];
                        st_d.vol_act = 1'b1;
                    end else if (st_q.wel) begin
                        st_d.nvsr = st_q.sh[7:0];
                        st_d.nv_wr = 1'b1;
                    end
                    st_d.wel = 1'b0;
                    st_d.vol_en = 1'b0;
                end
            end
        end

        // Reset pin overrides the mode, arm, enables and phase the frame set; a status write still lands
        // It is a level, so a long pulse keeps the state cleared
        // Both SR1 copies are kept; only power loss drops the volatile one
        if (!hw_rst_n) begin
            st_d.addr4 = 1'b0;
            st_d.armed = 1'b0;
            st_d.wel = 1'b0;
            st_d.vol_en = 1'b0;
            st_d.fsm = amr_pkg::amr_idle;
            st_d.evt[`AMR_EVT_HRST] = 1'b1;
        end

        // Active SR1 follows the volatile copy once it is live
        // Taken from the next state so the output never lags its source
        st_d.sr1 = st_d.vol_act ? st_d.vsr : st_d.nvsr;
    end

    // ======================================================
    // State register; power-up leaves 3-byte mode
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Chip select idles high; a zero here would look like the
            // end of a frame on the first clock after reset
            st_q <= '0;
            st_q.cs_q <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================
    // Outputs straight from flops
    // nv_data always shows the stored copy; nv_wr marks when to keep it
    assign apb_rsp = st_q.rsp;
    assign addr4_mode = st_q.addr4;
    assign sr1_out = st_q.sr1;
    assign nv_wr = st_q.nv_wr;
    assign nv_data = st_q.nvsr;

endmodule

// >>> verilog/amr_pkg.sv
// Types shared by the address mode and reset controller
package amr_pkg;

    // ======================================================
    // Serial frame states, Gray along idle-cmd-adr-dat
    typedef enum logic [2:0] {
        amr_idle = 3'h0,
        amr_cmd = 3'h1,
        amr_adr = 3'h3,
        amr_dat = 3'h2,
        amr_mode = 3'h6
    } amr_fsm_t;

    // ======================================================
    // Bus and pin carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } amr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } amr_apb_rsp_t;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic [3:0] io;
    } amr_spi_t;

    // ======================================================
    // Whole state of the controller
    typedef struct packed {
        amr_fsm_t fsm;
        logic sck_q;
        logic cs_q;
        logic [31:0] sh;
        logic [6:0] nbits;
        logic [6:0] need;
        logic [7:0] opc;
        logic [7:0] last_opc;
        logic [3:0] ffcnt;
        logic [1:0] width;
        logic addr4;
        logic armed;
        logic wel;
        logic vol_en;
        logic vol_act;
        logic cont;
        logic loaded;
        logic [7:0] nvsr;
        logic [7:0] vsr;
        logic [7:0] sr1;
        logic nv_wr;
        logic [31:0] addr;
        logic [1:0] evt;
        amr_apb_rsp_t rsp;
    } amr_st_t;

endpackage

// >>> verilog/amr_regs.svh
// Register offsets, field positions, opcodes and parameter word fields
`ifndef AMR_REGS_SVH
`define AMR_REGS_SVH

// ==========================================================
// Register byte offsets
`define AMR_CTRL_OFS 8'h00
`define AMR_STAT_OFS 8'h04
`define AMR_EVT_OFS 8'h08
`define AMR_SR1_OFS 8'h0c
`define AMR_ADDR_OFS 8'h10
`define AMR_SFDP_OFS 8'h14
`define AMR_OPC_OFS 8'h18

// ==========================================================
// Field positions and reset values
`define AMR_CTRL_CONT 2
`define AMR_EVT_SRST 0
`define AMR_EVT_HRST 1
`define AMR_WIDTH_RST 2'h0

// ==========================================================
// Serial instructions
`define AMR_OP_EN4B 8'hb7
`define AMR_OP_EX4B 8'he9
`define AMR_OP_RSTEN 8'h66
`define AMR_OP_RST 8'h99
`define AMR_OP_WREN 8'h06
`define AMR_OP_VWREN 8'h50
`define AMR_OP_WRSR 8'h01
`define AMR_OP_READ 8'h03
`define AMR_OP_PP 8'h02
`define AMR_OP_SE 8'h20
`define AMR_OP_READ4 8'h13
`define AMR_OP_PP4 8'h12
`define AMR_OP_SE4 8'h21

// ==========================================================
// Parameter word fields and timing
`define AMR_SFDP_ENTRY 8'h25
`define AMR_SFDP_EXIT 10'h0e5
`define AMR_SFDP_SRST 6'h30
`define AMR_SFDP_RFU 1'h1
`define AMR_SFDP_SR1WE 7'h68
`define AMR_CONT_EXIT_CLKS 4'h8
`define AMR_ALL_ONES 4'hf

`endif
